// file: logic/sehc_defs.vh
`ifndef SEHC_DEFS_VH
`define SEHC_DEFS_VH

// ****************************************
// Opcodes, first byte after select falls
// ****************************************
`define SEHC_OP_WRSR      8'h01
`define SEHC_OP_WRITE     8'h02
`define SEHC_OP_READ      8'h03
`define SEHC_OP_WRDI      8'h04
`define SEHC_OP_STAT_RD   8'h05
`define SEHC_OP_WR_EN     8'h06

// ****************************************
// Address field and array geometry
// ****************************************
`define SEHC_ADDR_BITS    16
`define SEHC_ARRAY_AW     12
`define SEHC_PAGE_AW      5

// ****************************************
// Status byte layout and fixed values
// ****************************************
`define SEHC_SR_BUSY      0
`define SEHC_SR_LATCH     1
`define SEHC_SR_BP0       2
`define SEHC_SR_BP1       3
`define SEHC_SR_WPEN      7
`define SEHC_SR_BUSY_BYTE 8'hFF
`define SEHC_SR_RESET     8'h00

// ****************************************
// Timing
// ****************************************
`define SEHC_CLK_MHZ      40
`define SEHC_T_WRITE_US   5
`define SEHC_WRITE_CYCLES (`SEHC_T_WRITE_US * `SEHC_CLK_MHZ)

`endif

// file: logic/sehc_mem.v
// ****************************************
// Array storage, registered read data
// ****************************************
module sehc_mem #(
   parameter P_AW = 12,
   parameter P_DW = 8
) (
   // Clock
   input  wire            i_sys_clk,
   // Write port
   input  wire            i_we,
   input  wire [P_AW-1:0] i_addr,
   input  wire [P_DW-1:0] i_wdata,
   // Read port
   output reg  [P_DW-1:0] o_rdata
);

   // Storage words
   reg [P_DW-1:0] mem [0:(1<<P_AW)-1];

   // Write when enabled; read into the output register every cycle
   always @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
   end

endmodule

// file: logic/sehc_ctrl.v
// What this block does
// - Drive addressed byte right after last address bit
// - Pointer advances per byte shifted out
// - Pointer wraps to zero, reading unbounded
// - Select high ends read, context dropped
// - Status byte shifted out after status opcode
// - Status read accepted always, even while busy
// - Status read while busy returns all ones
// - Paused: output released, data input ignored
// - Reset release gives standby, latch cleared
// - Writes refused until write enable accepted
// - Each select fall starts a new instruction
// - Finished write cycle clears write enable latch
// - Programming starts on select rise, exact count
// - Commands other than status read ignored during programming, programming continues
// - Unknown opcode ignored, output stays released
// - Read opcode 03h, status read opcode 05h
// - Status bit 0 is busy flag
// - Only low 12 address bits select location
// - Serial modes 0 and 3 supported
`include "sehc_defs.vh"

module sehc_ctrl #(
   parameter P_WRITE_CYCLES = `SEHC_WRITE_CYCLES,
   parameter P_WCNT_W       = 18
) (
   // Clock and power-on reset
   input  wire i_sys_clk,
   input  wire i_resetn,
   // Serial pins
   input  wire i_cs_n,
   input  wire i_sck,
   input  wire i_si,
   input  wire i_hold_n,
   output reg  o_so,
   output reg  o_so_oe,
   // Status
   output reg  o_busy,
   output reg  o_write_enable_latch,
   output reg  o_standby
);

   // ****************************************
   // States
   // ****************************************
   localparam ST_IDLE   = 3'd0;
   localparam ST_OPCODE = 3'd1;
   localparam ST_ADDR   = 3'd2;
   localparam ST_RDATA  = 3'd3;
   localparam ST_WDATA  = 3'd4;
   localparam ST_SRIN   = 3'd5;
   localparam ST_DONE   = 3'd6;
   localparam ST_IGNORE = 3'd7;

   // ****************************************
   // Signals
   // ****************************************
   reg  [1:0]                 cs_sync;      // Select synchroniser
   reg  [1:0]                 sck_sync;     // Clock synchroniser
   reg  [1:0]                 si_sync;      // Data synchroniser
   reg  [1:0]                 hold_sync;    // Pause synchroniser
   reg                        cs_d;         // Select, previous
   reg                        sck_d;        // Clock, previous
   reg  [2:0]                 state;        // Transfer state
   reg  [3:0]                 bit_cnt;      // Bits of current field
   reg  [7:0]                 shift_in;     // Received bits
   reg  [`SEHC_ADDR_BITS-1:0] addr_in;      // Received address
   reg  [7:0]                 pend_op;      // Opcode awaiting select rise
   reg                        src_status;   // Output source is status
   reg  [2:0]                 out_idx;      // Output bit index
   reg  [7:0]                 shift_out;    // Outgoing bits
   reg                        out_on;       // Output phase started
   reg  [`SEHC_ARRAY_AW-1:0]  ptr;          // Read pointer
   reg  [`SEHC_ARRAY_AW-1:0]  waddr;        // Write address
   reg  [7:0]                 wbuf;         // Write data
   reg                        have_byte;    // Write data seen
   reg  [7:0]                 sr_in;        // Status write data
   reg                        held;         // Pause in force
   reg                        busy;         // Programming running
   reg  [P_WCNT_W-1:0]        wcnt;         // Programming timer
   reg                        we_latch;     // Write enable latch
   reg                        wpen;         // Non-volatile status bits
   reg                        bp1;
   reg                        bp0;
   reg                        mem_we;       // Array write strobe
   wire [7:0]                 mem_rdata;    // Array read data
   wire                       cs_s;
   wire                       sck_s;
   wire                       si_s;
   wire                       hold_s;
   wire                       sck_rise;
   wire                       sck_fall;
   wire                       cs_fall;
   wire                       cs_rise;
   wire [7:0]                 rx_byte;
   wire [7:0]                 out_byte;

   // ****************************************
   // Helpers
   // ****************************************
   // Status byte as seen by a reader
   function [7:0] status_byte;
      input b;
      input w;
      input p;
      input q1;
      input q0;
      begin
         status_byte = `SEHC_SR_RESET;
         if (b) begin
            status_byte = `SEHC_SR_BUSY_BYTE;
         end else begin
            status_byte[`SEHC_SR_LATCH] = w;
            status_byte[`SEHC_SR_WPEN] = p;
            status_byte[`SEHC_SR_BP1]  = q1;
            status_byte[`SEHC_SR_BP0]  = q0;
         end
      end
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Two stages on every pin
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cs_sync   <= 2'h3;
         sck_sync  <= 2'h0;
         si_sync   <= 2'h0;
         hold_sync <= 2'h3;
         cs_d      <= 1'b1;
         sck_d     <= 1'b0;
      end else begin
         cs_sync   <= {cs_sync[0], i_cs_n};
         sck_sync  <= {sck_sync[0], i_sck};
         si_sync   <= {si_sync[0], i_si};
         hold_sync <= {hold_sync[0], i_hold_n};
         cs_d      <= cs_sync[1];
         sck_d     <= sck_sync[1];
      end
   end

   assign cs_s     = cs_sync[1];
   assign sck_s    = sck_sync[1];
   assign si_s     = si_sync[1];
   assign hold_s   = hold_sync[1];
   // Clock edges are seen only while selected and not paused
   assign sck_rise = sck_s & ~sck_d & ~cs_s & ~held;
   assign sck_fall = ~sck_s & sck_d & ~cs_s & ~held;
   assign cs_fall  = ~cs_s & cs_d;
   assign cs_rise  = cs_s & ~cs_d;
   assign rx_byte  = {shift_in[6:0], si_s};
   assign out_byte = src_status ? status_byte(busy, we_latch, wpen, bp1, bp0) : mem_rdata;

   // ****************************************
   // Pause control
   // ****************************************
   // Enter and leave while the clock is low; deselect also leaves at once
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         held <= 1'b0;
      end else if (cs_s) begin
         held <= 1'b0;
      end else if (!sck_s) begin
         held <= ~hold_s;
      end
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state      <= ST_IDLE;
         bit_cnt    <= 4'h0;
         shift_in   <= 8'h00;
         addr_in    <= 16'h0000;
         pend_op    <= 8'h00;
         src_status <= 1'b0;
         out_idx    <= 3'h0;
         shift_out  <= 8'h00;
         out_on     <= 1'b0;
         ptr        <= 12'h000;
         waddr      <= 12'h000;
         wbuf       <= 8'h00;
         have_byte  <= 1'b0;
         sr_in      <= 8'h00;
         o_so       <= 1'b0;
      end else if (cs_s) begin
         // Deselected: drop all transfer context
         state     <= ST_IDLE;
         out_on    <= 1'b0;
         have_byte <= 1'b0;
      end else if (cs_fall) begin
         // Every select fall opens a new instruction
         state     <= ST_OPCODE;
         bit_cnt   <= 4'h0;
         out_idx   <= 3'h0;
         out_on    <= 1'b0;
         have_byte <= 1'b0;
      end else if (sck_rise) begin
         shift_in <= rx_byte;
         case (state)
            ST_OPCODE: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7) begin
                  bit_cnt <= 4'h0;
                  pend_op <= rx_byte;
                  if (rx_byte == `SEHC_OP_STAT_RD) begin
                     state      <= ST_RDATA;
                     src_status <= 1'b1;
                  end else if (busy) begin
                     state <= ST_IGNORE;
                  end else if (rx_byte == `SEHC_OP_READ) begin
                     state      <= ST_ADDR;
                     src_status <= 1'b0;
                  end else if (rx_byte == `SEHC_OP_WRITE && we_latch) begin
                     state <= ST_ADDR;
                  end else if (rx_byte == `SEHC_OP_WRSR && we_latch) begin
                     state <= ST_SRIN;
                  end else if (rx_byte == `SEHC_OP_WR_EN || rx_byte == `SEHC_OP_WRDI) begin
                     state <= ST_DONE;
                  end else begin
                     state <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR: begin
               addr_in <= {addr_in[14:0], si_s};
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'hF) begin
                  bit_cnt <= 4'h0;
                  // Upper address bits are don't-care
                  ptr   <= {addr_in[10:0], si_s};
                  waddr <= {addr_in[10:0], si_s};
                  state <= (pend_op == `SEHC_OP_READ) ? ST_RDATA : ST_WDATA;
               end
            end
            ST_WDATA: begin
               bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
               if (bit_cnt[2:0] == 3'h7) begin
                  wbuf      <= rx_byte;
                  have_byte <= 1'b1;
                  // Later bytes advance within the page only
                  if (have_byte) begin
                     waddr[`SEHC_PAGE_AW-1:0] <= waddr[`SEHC_PAGE_AW-1:0] + 5'h01;
                  end
               end
            end
            ST_SRIN: begin
               bit_cnt <= bit_cnt + 4'h1;
               if (bit_cnt == 4'h7) begin
                  sr_in <= rx_byte;
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               // Any extra clock spoils the command
               state <= ST_IGNORE;
            end
            ST_RDATA: begin
               state <= ST_RDATA;
            end
            ST_IGNORE: begin
               state <= ST_IGNORE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end else if (sck_fall && state == ST_RDATA) begin
         // Shift out, most significant bit first
         out_on  <= 1'b1;
         out_idx <= out_idx + 3'h1;
         if (out_idx == 3'h0) begin
            o_so      <= out_byte[7];
            shift_out <= {out_byte[6:0], 1'b0};
            // Natural overflow wraps to address zero
            ptr       <= ptr + 12'h001;
         end else begin
            o_so      <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
      end
   end

   // ****************************************
   // Output enable
   // ****************************************
   // Released when paused, idle or ignoring
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_so_oe <= 1'b0;
      end else begin
         o_so_oe <= out_on & ~held & ~cs_s & (state == ST_RDATA);
      end
   end

   // ****************************************
   // Write enable latch and programming
   // ****************************************
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         we_latch <= 1'b0;
         busy   <= 1'b0;
         wcnt   <= {P_WCNT_W{1'b0}};
         wpen   <= 1'b0;
         bp1    <= 1'b0;
         bp0    <= 1'b0;
         mem_we <= 1'b0;
      end else begin
         mem_we <= 1'b0;
         if (busy) begin
            // Timer runs to the end regardless of the pins
            wcnt <= wcnt - {{(P_WCNT_W-1){1'b0}}, 1'b1};
            if (wcnt == {{(P_WCNT_W-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               we_latch <= 1'b0;
            end
         end else if (cs_rise && state == ST_DONE) begin
            if (pend_op == `SEHC_OP_WR_EN) begin
               we_latch <= 1'b1;
            end else if (pend_op == `SEHC_OP_WRDI) begin
               we_latch <= 1'b0;
            end else begin
               // Status write: only the writable bits
               wpen <= sr_in[`SEHC_SR_WPEN];
               bp1  <= sr_in[`SEHC_SR_BP1];
               bp0  <= sr_in[`SEHC_SR_BP0];
               busy <= 1'b1;
               wcnt <= P_WRITE_CYCLES[P_WCNT_W-1:0];
            end
         end else if (cs_rise && state == ST_WDATA && have_byte && bit_cnt == 4'h0) begin
            // Whole bytes only start programming
            mem_we <= 1'b1;
            busy   <= 1'b1;
            wcnt   <= P_WRITE_CYCLES[P_WCNT_W-1:0];
         end
      end
   end

   // ****************************************
   // Status outputs
   // ****************************************
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_busy               <= 1'b0;
         o_write_enable_latch <= 1'b0;
         o_standby            <= 1'b1;
      end else begin
         o_busy               <= busy;
         o_write_enable_latch <= we_latch;
         o_standby            <= cs_s & ~busy;
      end
   end

   // ****************************************
   // Array
   // ****************************************
   sehc_mem #(
      .P_AW (`SEHC_ARRAY_AW),
      .P_DW (8)
   ) u_mem (
      .i_sys_clk (i_sys_clk),
      .i_we      (mem_we),
      .i_addr    (mem_we ? waddr : ptr),
      .i_wdata   (wbuf),
      .o_rdata   (mem_rdata)
   );

endmodule

// file: dv/sehc_ctrl_monitor.sv
// ****************************************
// Port checker for the serial memory control
// ****************************************
module sehc_ctrl_monitor #(
   parameter P_WRITE_CYCLES = 200
) (
   // Clock and reset
   input wire i_sys_clk,
   input wire i_resetn,
   // Serial pins
   input wire i_cs_n,
   input wire i_sck,
   input wire i_si,
   input wire i_hold_n,
   input wire o_so,
   input wire o_so_oe,
   // Status
   input wire o_busy,
   input wire o_write_enable_latch,
   input wire o_standby
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   logic [31:0] busy_cnt; // Cycles the programming cycle has lasted

   // Count busy cycles, cleared when idle
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         busy_cnt <= 32'h0000_0000;
      end else if (o_busy) begin
         busy_cnt <= busy_cnt + 32'h0000_0001;
      end else begin
         busy_cnt <= 32'h0000_0000;
      end
   end

   reset_state_a: assert property (disable iff (1'b0) !i_resetn |-> !o_so_oe && !o_busy && !o_write_enable_latch)
      else $error("outputs not cleared in reset");
   select_wakes_a: assert property (!i_cs_n [*6] |-> !o_standby)
      else $error("standby kept while selected");
   deselect_off_a: assert property (i_cs_n [*6] |-> !o_so_oe)
      else $error("output driven while deselected");
   pause_off_a: assert property (!i_hold_n [*6] |-> !o_so_oe)
      else $error("output driven while paused");
   shift_on_fall_a: assert property (o_so_oe && $past(o_so_oe) && $changed(o_so) |-> !$past(i_sck, 3))
      else $error("output bit changed away from a clock fall");
   busy_length_a: assert property ($fell(o_busy) |-> busy_cnt == P_WRITE_CYCLES)
      else $error("programming cycle length wrong");
   latch_cleared_a: assert property ($fell(o_busy) |-> ##[0:1] !o_write_enable_latch)
      else $error("write enable latch kept after programming");
   write_needs_latch_a: assert property ($rose(o_busy) |-> o_write_enable_latch)
      else $error("programming started with writes disabled");
   busy_latch_hold_a: assert property (o_busy && $past(o_busy) |-> $stable(o_write_enable_latch))
      else $error("latch changed during programming");
   oe_start_a: assert property ($rose(o_so_oe) |-> !i_cs_n && i_hold_n)
      else $error("output enabled while deselected or paused");

   cover property ($rose(o_busy));
   cover property ($rose(o_so_oe));
   cover property (!i_hold_n && !i_cs_n);
endmodule

// file: dv/sehc_host.sv
// ****************************************
// Serial host model, modes 0 and 3
// ****************************************
module sehc_host (
   // Clock
   input  wire logic i_sys_clk,
   // Device pins
   output logic      o_cs_n,
   output logic      o_sck,
   output logic      o_si,
   output logic      o_hold_n,
   input  wire logic i_so
);
   timeunit 1ns;
   timeprecision 1ps;

   logic idle_hi = 1'b0; // Clock idle level, high for mode 3

   // Idle pins at time zero
   initial begin
      o_cs_n   = 1'b1;
      o_sck    = 1'b0;
      o_si     = 1'b0;
      o_hold_n = 1'b1;
   end

   // Wait falling system clock edges
   task automatic wait_clk(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   // One bit: data set at clock fall, read back just before next fall
   task automatic bit_io(input logic b, output logic r);
      o_sck = 1'b0;
      o_si  = b;
      wait_clk(4);
      o_sck = 1'b1;
      wait_clk(4);
      r = i_so;
   endtask

   // Whole byte, most significant bit first
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
   endtask

   // Select with the clock at its idle level
   task automatic select();
      o_sck  = idle_hi;
      wait_clk(4);
      o_cs_n = 1'b0;
      wait_clk(4);
   endtask

   // Release after whole bytes; data line stops holding its value
   task automatic deselect();
      wait_clk(2);
      o_sck  = idle_hi;
      wait_clk(2);
      o_cs_n = 1'b1;
      o_si   = ~o_si;
      wait_clk(12);
   endtask

   // Pause or resume with clock low and select kept low
   task automatic hold_set(input logic v);
      o_sck    = 1'b0;
      wait_clk(4);
      o_hold_n = v;
      o_si     = ~o_si;
      wait_clk(8);
   endtask
endmodule

// file: dv/testbench.sv
// ****************************************
// Testbench for the serial memory control
// ****************************************
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int WCYC = 800; // Programming time four times the default

   logic       i_sys_clk = 1'b0; // System clock
   logic       i_resetn  = 1'b1; // Power-on reset, driven low at the first falling edge
   logic       cs_n, sck, si, hold_n;
   wire        so, so_oe, busy, we_latch, standby;
   logic [7:0] rx;
   int         error_cnt  = 0;
   int         num_checks = 0;
   int         cyc        = 0;

   always #12.5 i_sys_clk = ~i_sys_clk;

   sehc_ctrl #(.P_WRITE_CYCLES(WCYC), .P_WCNT_W(18)) dut_u (
      .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
      .i_hold_n(hold_n), .o_so(so), .o_so_oe(so_oe), .o_busy(busy),
      .o_write_enable_latch(we_latch), .o_standby(standby));

   // A released output shows the inverse of its last bit, so reads while released fail
   sehc_host host_u (
      .i_sys_clk(i_sys_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .o_hold_n(hold_n),
      .i_so(so_oe ? so : ~so));

   // Compare one value
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Report and end the run
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Opcode alone, then release
   task automatic cmd(input logic [7:0] op);
      host_u.select();
      host_u.byte_io(op, rx);
      host_u.deselect();
   endtask

   // Leading nb bytes of w in one selection, left selected
   task automatic frame(input logic [31:0] w, input int nb = 4);
      host_u.select();
      for (int i = 3; i >= 4 - nb; i--) host_u.byte_io(w[8*i+:8], rx);
   endtask

   // Enabled single byte write
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      cmd(8'h06);
      frame({8'h02, a, d});
      host_u.deselect();
   endtask

   // Bounded wait for programming to end
   task automatic wait_idle();
      for (int n = 0; n < 2 * WCYC && busy !== 1'b0; n++) @(negedge i_sys_clk);
      check({7'h00, busy}, 8'h00);
   endtask

   // Hang guard
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         complete_run();
      end
   end

   // Main sequence
   initial begin
      @(negedge i_sys_clk);
      i_resetn = 1'b0;
      repeat (16) @(negedge i_sys_clk);
      i_resetn = 1'b1;
      @(negedge i_sys_clk);
      check({5'h00, busy, we_latch, so_oe}, 8'h00);
      check({7'h00, standby}, 8'h01);
      frame({8'h02, 16'h0001, 8'h77});
      host_u.deselect();
      check({6'h00, busy, we_latch}, 8'h00);
      cmd(8'h06);
      host_u.idle_hi = 1'b1;
      frame({8'h05, 24'h5A_5A5A});
      check(rx, 8'h02);
      host_u.deselect();
      host_u.idle_hi = 1'b0;
      frame({8'h02, 16'hFFFF, 8'hA5});
      host_u.deselect();
      check({7'h00, busy}, 8'h01);
      frame({8'h05, 24'h5A_5A5A});
      check(rx, 8'hFF);
      host_u.deselect();
      frame({8'h03, 16'h0FFF, 8'h00});
      check({7'h00, so_oe}, 8'h00);
      host_u.deselect();
      wait_idle();
      frame({8'h05, 24'h5A_5A5A});
      check(rx, 8'h00);
      host_u.deselect();
      wr(16'h0000, 8'h3C);
      wait_idle();
      wr(16'h0001, 8'h96);
      wait_idle();
      frame({8'hAB, 24'h00_0000});
      check({7'h00, so_oe}, 8'h00);
      host_u.deselect();
      frame({8'h03, 16'hAFFF, 8'h5A});
      check(rx, 8'hA5);
      host_u.hold_set(1'b0);
      check({7'h00, so_oe}, 8'h00);
      host_u.hold_set(1'b1);
      host_u.byte_io(8'h5A, rx);
      check(rx, 8'h3C);
      host_u.byte_io(8'h5A, rx);
      check(rx, 8'h96);
      host_u.deselect();
      check({7'h00, so_oe}, 8'h00);
      // Write disable drops the latch again
      cmd(8'h06);
      cmd(8'h04);
      check({7'h00, we_latch}, 8'h00);
      // Status write: bits 7, 3 and 2 land, latch drops at the end
      cmd(8'h06);
      frame({8'h01, 8'h8C, 16'h0000}, 2);
      host_u.deselect();
      check({7'h00, busy}, 8'h01);
      wait_idle();
      frame({8'h05, 24'h5A_5A5A});
      check(rx, 8'h8C);
      host_u.deselect();
      cmd(8'h06);
      i_resetn = 1'b0;
      repeat (2) @(negedge i_sys_clk);
      check({7'h00, we_latch}, 8'h00);
      i_resetn = 1'b1;
      @(negedge i_sys_clk);
      check({7'h00, standby}, 8'h01);
      complete_run();
   end
endmodule

bind sehc_ctrl sehc_ctrl_monitor #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) mon_u (
   .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si),
   .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy),
   .o_write_enable_latch(o_write_enable_latch), .o_standby(o_standby));
